/* File: hdl/peak_hold_ramp_adc_sequencer.sv */
// sequencer for two alternating peak detectors and a ramp converter feeding a recirculating store
// assumes comparator and store inputs synchronous to sys_clk; base clock nominally 2.5 MHz
`timescale 1ns/1ps
`include "peak_hold_consts.svh"

// Operation
// - conversion instants come from a counter dividing the base clock by a preset plus one
// - peak held between instants so spikes appear at the next data point
// - a detector is discharged only after its output was captured
// - ramp converter counts clocks until ramp reaches the held level
// - cycle starts by freezing detector 2, then converting its level
// - detector 1 tracks, neither frozen nor discharged, during conversion
// - conversion done releases detector 2 freeze and starts its discharge
// - after its discharge detector 2 acquires detector 1's peak
// - detector 1 discharged just before next freeze, then sequence repeats
// - result held in counter, moved to store at next conversion start
// - store holds 513 eight-bit words; results written as eight-bit words
// - high definition uses 470 visible words; rest only during flyback
// - at most one store word per full recirculation
// - base clock for store and timing counters runs at 2.5 MHz
module peak_hold_ramp_adc_sequencer
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [`CONV_DIV_W-1:0] convDiv,
	input wire logic rampTrip,
	input wire logic recircStart,
	input wire logic hiDefMode,
	input wire logic flyback,
	output logic det1Discharge,
	output logic det2Freeze,
	output logic det2Discharge,
	output logic rampRun,
	output logic [`WORD_W-1:0] rampCount,
	output logic convDone,
	output logic storeWrite,
	output logic [`STORE_ADDR_W-1:0] storeAddr,
	output logic [`WORD_W-1:0] storeData,
	output logic [`STORE_ADDR_W-1:0] readAddr,
	output logic readValid
);
	// ----------------------------------------
	// conversion instant divider
	// ----------------------------------------
	// a zero seen mid-sequence is ignored, so presets shorter than a conversion skip instants
	logic [`CONV_DIV_W-1:0] divCnt_reg;
	logic [`CONV_DIV_W-1:0] divCnt_next;
	wire divZero = (divCnt_reg == '0);
	assign divCnt_next = divZero ? convDiv : divCnt_reg - 16'h0001;
	always_ff @(posedge sys_clk)
		if (srst)
			divCnt_reg <= `CONV_DIV_DEFAULT;
		else
			divCnt_reg <= divCnt_next;

	// ----------------------------------------
	// detector phase machine
	// ----------------------------------------
	peak_hold_pkg::seq_state_t state_reg;
	peak_hold_pkg::seq_state_t state_next;
	logic [7:0] disCnt_reg;
	logic [`WORD_W-1:0] ramp_reg;
	logic [`WORD_W-1:0] result_reg;
	logic resultValid_reg;
	logic pendWrite_reg;
	wire disEnd = (disCnt_reg == 8'h00);
	wire rampFull = (ramp_reg == `RAMP_MAX);
	// done in the trip cycle; a full-scale ramp also ends so a stuck comparator cannot hang
	wire doneNow = (state_reg == peak_hold_pkg::ST_CONVERT) && (rampTrip || rampFull);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			peak_hold_pkg::ST_IDLE: if (divZero) state_next = peak_hold_pkg::ST_DIS1;
			peak_hold_pkg::ST_DIS1: if (disEnd) state_next = peak_hold_pkg::ST_CONVERT;
			peak_hold_pkg::ST_CONVERT: if (doneNow) state_next = peak_hold_pkg::ST_DIS2;
			peak_hold_pkg::ST_DIS2: if (disEnd) state_next = peak_hold_pkg::ST_TRACK;
			peak_hold_pkg::ST_TRACK: if (divZero) state_next = peak_hold_pkg::ST_DIS1;
			default: state_next = peak_hold_pkg::ST_IDLE;
		endcase
	end

	wire enterDis = (state_next != state_reg) &&
		((state_next == peak_hold_pkg::ST_DIS1) || (state_next == peak_hold_pkg::ST_DIS2));
	wire enterConv = (state_reg == peak_hold_pkg::ST_DIS1) && disEnd;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_reg <= peak_hold_pkg::ST_IDLE;
			disCnt_reg <= 8'h00;
			ramp_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			disCnt_reg <= enterDis ? `DISCHARGE_CYCLES - 8'h01 :
				(disEnd ? 8'h00 : disCnt_reg - 8'h01);
			if (enterConv)
				ramp_reg <= 8'h00;
			else if (state_reg == peak_hold_pkg::ST_CONVERT && !doneNow)
				ramp_reg <= ramp_reg + 8'h01;
		end
	end

	// detector 1 discharge happens before freeze; detector 2 freezes only while converting
	assign det1Discharge = (state_reg == peak_hold_pkg::ST_DIS1);
	assign det2Freeze = (state_reg == peak_hold_pkg::ST_CONVERT);
	assign det2Discharge = (state_reg == peak_hold_pkg::ST_DIS2);
	assign rampRun = det2Freeze;
	assign convDone = doneNow;

	// ----------------------------------------
	// result hand-over to the store
	// ----------------------------------------
	// a slot that never arrives lets the next conversion start replace the queued word
	wire storeSlot = pendWrite_reg && recircStart;
	logic [`STORE_ADDR_W-1:0] wAddr_reg;
	wire wLast = (wAddr_reg == `STORE_LAST_ADDR);
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			result_reg <= 8'h00;
			resultValid_reg <= 1'b0;
			pendWrite_reg <= 1'b0;
			storeWrite <= 1'b0;
			storeData <= 8'h00;
			wAddr_reg <= '0;
		end
		else
		begin
			if (doneNow)
				result_reg <= ramp_reg;
			if (doneNow)
				resultValid_reg <= 1'b1;
			else if (enterConv)
				resultValid_reg <= 1'b0;
			// previous result queued at the start of the next conversion
			if (enterConv && resultValid_reg)
			begin
				pendWrite_reg <= 1'b1;
				storeData <= result_reg;
			end
			else if (storeSlot)
				pendWrite_reg <= 1'b0;
			storeWrite <= storeSlot;
			if (storeWrite)
				wAddr_reg <= wLast ? '0 : wAddr_reg + 10'h001;
		end
	end
	assign storeAddr = wAddr_reg;
	assign rampCount = ramp_reg;

	// ----------------------------------------
	// read-out window
	// ----------------------------------------
	logic [`STORE_ADDR_W-1:0] rAddr_reg;
	wire rLast = (rAddr_reg == `STORE_LAST_ADDR);
	wire visible = rAddr_reg <= `VISIBLE_LAST_ADDR;
	always_ff @(posedge sys_clk)
		if (srst)
			rAddr_reg <= '0;
		else
			rAddr_reg <= rLast ? '0 : rAddr_reg + 10'h001;
	assign readAddr = rAddr_reg;
	// in high definition, words past the visible area are only offered during flyback
	assign readValid = !hiDefMode || visible || flyback;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_EXCL: assert property (@(posedge sys_clk) disable iff (srst)
		$onehot0({det1Discharge, det2Freeze, det2Discharge}))
		else $error("detector controls overlap");
	AST_TRACK1: assert property (@(posedge sys_clk) disable iff (srst)
		det2Freeze |-> !det1Discharge)
		else $error("detector 1 disturbed during conversion");
	AST_RELEASE: assert property (@(posedge sys_clk) disable iff (srst)
		convDone |=> det2Discharge && !det2Freeze)
		else $error("freeze not released after done");
	AST_DONEGATE: assert property (@(posedge sys_clk) disable iff (srst)
		det2Freeze && !convDone |=> det2Freeze)
		else $error("freeze released without done");
	AST_DIS2LEN: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(det2Discharge) |-> det2Discharge[*4] ##1 !det2Discharge)
		else $error("detector 2 discharge length wrong");
	AST_DIS1FIRST: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(det2Freeze) |-> $past(det1Discharge))
		else $error("freeze without prior detector 1 discharge");
	AST_DIS2AFTER: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(det2Discharge) |-> $past(convDone))
		else $error("detector 2 discharged before capture");
	AST_RESULT: assert property (@(posedge sys_clk) disable iff (srst)
		convDone |=> result_reg == $past(rampCount))
		else $error("result not held");
	AST_ONEWR: assert property (@(posedge sys_clk) disable iff (srst)
		storeWrite |-> $past(recircStart))
		else $error("store write outside recirculation slot");
	AST_RAMP: assert property (@(posedge sys_clk) disable iff (srst)
		det2Freeze && !convDone |=> rampCount == $past(rampCount) + 8'h01)
		else $error("ramp did not count");
	AST_DIV: assert property (@(posedge sys_clk) disable iff (srst)
		divZero |=> divCnt_reg == $past(convDiv))
		else $error("divider not preset");
	AST_DIS1LEN: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(det1Discharge) |-> det1Discharge[*4] ##1 det2Freeze)
		else $error("detector 1 discharge length wrong");
	AST_HANDOVER: assert property (@(posedge sys_clk) disable iff (srst)
		enterConv && resultValid_reg |=> storeData == $past(result_reg))
		else $error("result not handed to the store");
	AST_WRADDR: assert property (@(posedge sys_clk) disable iff (srst)
		storeWrite |=> storeAddr == (($past(storeAddr) == `STORE_LAST_ADDR) ?
		10'h000 : $past(storeAddr) + 10'h001))
		else $error("store write address did not step");
	COV_CONV: cover property (@(posedge sys_clk) disable iff (srst) $rose(det2Freeze) ##[1:300] convDone);
	COV_WRITE: cover property (@(posedge sys_clk) disable iff (srst) storeWrite);
	COV_FLY: cover property (@(posedge sys_clk) disable iff (srst) hiDefMode && !visible && readValid);
	COV_ZERO: cover property (@(posedge sys_clk) disable iff (srst) $rose(det2Freeze) && convDone);
	COV_TRACK: cover property (@(posedge sys_clk) disable iff (srst)
		$fell(det2Discharge) ##[1:300] det1Discharge);
endmodule

/* File: hdl/peak_hold_consts.svh */
// timing and layout constants for the peak-hold ramp converter sequencer
// assumes inclusion by the sequencer module, the far-side model and the bench
`ifndef PEAK_HOLD_CONSTS_SVH
`define PEAK_HOLD_CONSTS_SVH

// ----------------------------------------
// data word and store
// ----------------------------------------
`define WORD_W 8
`define STORE_WORDS 513
`define STORE_ADDR_W 10
`define VISIBLE_WORDS 470
`define STORE_LAST_ADDR 10'h200
`define VISIBLE_LAST_ADDR 10'h1D5

// ----------------------------------------
// timing
// ----------------------------------------
`define BASE_CLK_KHZ 2500
`define CONV_DIV_W 16
`define CONV_DIV_DEFAULT 16'h0200
`define DISCHARGE_CYCLES 8'h04
`define RAMP_MAX 8'hFF

`endif

/* File: hdl/peak_hold_pkg.sv */
// types shared by the peak-hold sequencer
// assumes the constants header is compiled alongside
package peak_hold_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DIS1,
		ST_CONVERT,
		ST_DIS2,
		ST_TRACK
	} seq_state_t;
endpackage

/* File: verif/detector_store_model.sv */
// far-side model: peak comparator and the store's recirculation write slots
// assumes a single sys_clk domain; the bench sets the frozen peak level
`timescale 1ns/1ps
`include "peak_hold_consts.svh"
module detector_store_model #(parameter int RECIRC = 20)
(
	input wire logic sys_clk,
	input wire logic rampRun,
	input wire logic [`WORD_W-1:0] rampCount,
	input wire logic [`WORD_W-1:0] heldLevel,
	output logic rampTrip,
	output logic recircStart
);
	int slotCnt = 1;
	assign rampTrip = rampRun && (rampCount >= heldLevel);
	assign recircStart = (slotCnt == 0);
	always @(posedge sys_clk)
		slotCnt <= #10 ((slotCnt == RECIRC - 1) ? 0 : slotCnt + 1);
endmodule

/* File: verif/peak_hold_ramp_adc_sequencer_tb.sv */
// self-checking bench for the peak-hold ramp converter sequencer
// assumes the far-side model answers the ramp and offers write slots
`timescale 1ns/1ps
`include "peak_hold_consts.svh"
module peak_hold_ramp_adc_sequencer_tb;
	logic sys_clk = 1'b0, srst = 1'b1, hiDefMode = 1'b0, flyback = 1'b0;
	logic [`WORD_W-1:0] heldLevel = 8'h00;
	// divide count kept small so several instants fit in a short run
	logic [`CONV_DIV_W-1:0] convDiv = 16'h0063;
	logic rampTrip, recircStart, det1Discharge, det2Freeze, det2Discharge, rampRun;
	logic convDone, storeWrite, readValid;
	logic [`WORD_W-1:0] rampCount, storeData;
	logic [`STORE_ADDR_W-1:0] storeAddr, readAddr;
	logic [17:0] wq[$];
	wire [2:0] ctl = {det1Discharge, det2Freeze, det2Discharge};
	int miscompares = 0, comparisons = 0;
	time lastStart = 0;
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (storeWrite === 1'b1)
			wq.push_back({storeAddr, storeData});
	peak_hold_ramp_adc_sequencer i_peak_hold_ramp_adc_sequencer (
		.sys_clk(sys_clk), .srst(srst), .convDiv(convDiv), .rampTrip(rampTrip),
		.recircStart(recircStart), .hiDefMode(hiDefMode), .flyback(flyback),
		.det1Discharge(det1Discharge), .det2Freeze(det2Freeze), .det2Discharge(det2Discharge),
		.rampRun(rampRun), .rampCount(rampCount), .convDone(convDone), .storeWrite(storeWrite),
		.storeAddr(storeAddr), .storeData(storeData), .readAddr(readAddr), .readValid(readValid));
	detector_store_model i_detector_store_model (.sys_clk(sys_clk), .rampRun(rampRun),
		.rampCount(rampCount), .heldLevel(heldLevel), .rampTrip(rampTrip), .recircStart(recircStart));
	task automatic chkw(input logic [17:0] got, input logic [17:0] exp);
		comparisons++;
		if (got !== exp)
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		miscompares += int'(got !== exp);
	endtask
	task automatic phase(input logic [2:0] exp, input int n);
		repeat (n)
		begin
			chkw(18'(ctl), 18'(exp));
			@(posedge sys_clk) #10;
		end
	endtask
	task automatic wait_on(input bit onDone);
		int n;
		for (n = 0; n < 700 && (onDone ? convDone : det1Discharge) !== 1'b1; n++)
			@(posedge sys_clk) #10;
		chkw(18'(n < 700), 18'h00001);
	endtask
	task automatic conv_test(input logic [`WORD_W-1:0] lvl);
		heldLevel = lvl;
		wait_on(1'b0);
		if (lastStart != 0)
			chkw(18'(($time - lastStart) / 100), 18'(convDiv) + 18'h00001);
		lastStart = $time;
		phase(3'b100, 4);
		chkw({ctl, 6'h00, rampRun, rampCount}, {3'b010, 6'h00, 1'b1, 8'h00});
		wait_on(1'b1);
		chkw({ctl, 6'h00, rampRun, rampCount}, {3'b010, 6'h00, 1'b1, lvl});
		@(posedge sys_clk) #10;
		phase(3'b001, 4);
		phase(3'b000, 1);
	endtask
	task automatic store_test();
		logic [`WORD_W-1:0] lv[4] = '{8'h00, 8'h01, 8'h3C, 8'h40};
		foreach (lv[i])
			conv_test(lv[i]);
		chkw(18'(wq.size()), 18'h00003);
		foreach (wq[i])
			chkw(wq[i], {10'(i), lv[i]});
		$display("store hand-over test done");
	endtask
	task automatic rate_test();
		convDiv = 16'h0077;
		lastStart = 0;
		conv_test(8'h10);
		conv_test(8'h20);
		$display("conversion rate test done");
	endtask
	task automatic read_test();
		logic [`STORE_ADDR_W-1:0] ra;
		bit vs;
		ra = readAddr;
		for (int k = 0; k < 2080; k++)
		begin
			{flyback, hiDefMode} = 2'(k / 520);
			@(posedge sys_clk) #10;
			ra = (ra == `STORE_LAST_ADDR) ? 10'h000 : ra + 10'h001;
			chkw(18'(readAddr), 18'(ra));
			vs = !hiDefMode || ra <= `VISIBLE_LAST_ADDR || flyback;
			chkw(18'(readValid), 18'(vs));
		end
		$display("read window test done");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		#10 srst = 1'b0;
		store_test();
		rate_test();
		read_test();
		wrap_up();
	end
	initial
	begin
		#1000000;
		miscompares++;
		$display("ERROR %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
